// ===== src/rmcs_pkg.sv
// package: clock-switch modes, status struct, phase and pipeline constants
package rmcs_pkg;
  typedef enum logic [1:0] {SRC_PRIMARY, SRC_SECONDARY, SRC_INTERNAL} rmcs_src_t;
  typedef struct packed {
    logic secondaryOscActiveFlag;
    logic oscStartTimeoutFlag;
    logic primaryOscEnable;
    logic secondaryOscEnable;
  } rmcs_status_t;
  localparam int          SEL_W         = 2;
  localparam int          FREQ_W        = 3;
  localparam int          PC_W          = 21;
  localparam int          INSN_W        = 16;
  localparam int          PHASE_W       = 2;
  localparam logic [1:0]  PH_ONE        = 2'h0;
  localparam logic [1:0]  PH_TWO        = 2'h1;
  localparam logic [1:0]  PH_THREE      = 2'h2;
  localparam logic [1:0]  PH_FOUR       = 2'h3;
  localparam int          SEL_UPPER_BIT = 1;
  localparam int          SEL_LOWER_BIT = 0;
  localparam logic [1:0]  SEL_PRIMARY   = 2'h0;
  localparam logic [1:0]  SEL_SECONDARY = 2'h1;
  localparam logic [20:0] PC_STEP       = 21'h000001;
  localparam logic [15:0] INSN_NOP      = 16'h0000;
  localparam logic [2:0]  FREQ_RESET    = 3'h0;
endpackage

// ===== src/rmcs_clock_switch.sv
// clock source switch, quadrature phase generator and fetch/execute pipeline
`timescale 1ns/1ps
module rmcs_clock_switch
  import rmcs_pkg::*;
(
  input  wire logic                clock,
  input  wire logic                rst_n,
  input  wire logic [SEL_W-1:0]    clockSourceSelect,
  input  wire logic                idleOnSleepEnable,
  input  wire logic [FREQ_W-1:0]   internalFreqSelect,
  input  wire logic                primaryReadyPin,
  input  wire logic [INSN_W-1:0]   progMemData,
  input  wire logic                branchTaken,
  input  wire logic [PC_W-1:0]     branchTarget,
  output rmcs_src_t                activeSource,
  output rmcs_status_t             status,
  output logic [SEL_W-1:0]         clockSourceSelectEcho,
  output logic                     idleOnSleepEcho,
  output logic [FREQ_W-1:0]        internalFreqOut,
  output logic [PHASE_W-1:0]       phase,
  output logic [PC_W-1:0]          progCounter,
  output logic [INSN_W-1:0]        instrReg,
  output logic                     instrValid,
  output logic                     operandRead,
  output logic                     destWrite
);

  // external ready pin crosses into our clock
  // held clear while the primary is off, so a stale ready cannot outlive a restart
  logic primReadySync1_r;
  logic primReadySync2_r;
  logic primEnable_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      primReadySync1_r <= 1'b0;
      primReadySync2_r <= 1'b0;
    end
    else if (!primEnable_r)
    begin
      primReadySync1_r <= 1'b0;
      primReadySync2_r <= 1'b0;
    end
    else
    begin
      primReadySync1_r <= primaryReadyPin;
      primReadySync2_r <= primReadySync1_r;
    end
  end

  function automatic rmcs_src_t decodeSel(input logic [SEL_W-1:0] sel);
    if (sel[SEL_UPPER_BIT])
      decodeSel = SRC_INTERNAL;
    else if (sel == SEL_SECONDARY)
      decodeSel = SRC_SECONDARY;
    else
      decodeSel = SRC_PRIMARY;
  endfunction

  // phase counter, a divide by four of the system clock
  logic [PHASE_W-1:0] phase_r;
  logic               cycleEnd;
  assign cycleEnd = (phase_r == PH_FOUR);
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      phase_r <= PH_ONE;
    else
      phase_r <= phase_r + 2'h1;
  end
  assign phase = phase_r;

  // source selection
  rmcs_src_t requested;
  rmcs_src_t active_r;
  logic      secActive_r;
  logic      timeout_r;
  logic      secEnable_r;
  logic      switchPending_r;
  logic      switchReady;
  assign requested = decodeSel(clockSourceSelect);

  // a primary move waits for its oscillator; others need only the boundary
  always_comb
  begin
    switchReady = 1'b1;
    if (requested == SRC_PRIMARY)
      switchReady = primReadySync2_r;
  end

  // switch delay: request registered, then applied at a cycle boundary
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      switchPending_r <= 1'b0;
    else
      switchPending_r <= (requested != active_r);
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      active_r <= SRC_PRIMARY;
    else if (switchPending_r && (requested != active_r) && switchReady && cycleEnd)
      active_r <= requested;
  end
  assign activeSource = active_r;

  // primary oscillator enable
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      primEnable_r <= 1'b1;
    else if (active_r == SRC_INTERNAL && requested == SRC_INTERNAL)
      primEnable_r <= 1'b0;
    else if (requested == SRC_PRIMARY)
      primEnable_r <= 1'b1;
  end

  // secondary oscillator enable; never stopped by a return to primary
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      secEnable_r <= 1'b0;
    else if (requested == SRC_SECONDARY)
      secEnable_r <= 1'b1;
  end

  // status flags
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      secActive_r <= 1'b0;
      timeout_r   <= 1'b0;
    end
    else
    begin
      secActive_r <= (active_r == SRC_SECONDARY);
      if (active_r == SRC_PRIMARY)
        timeout_r <= primReadySync2_r;
      else if (active_r == SRC_INTERNAL)
        timeout_r <= 1'b0;
    end
  end

  assign status.secondaryOscActiveFlag = secActive_r;
  assign status.oscStartTimeoutFlag    = timeout_r;
  assign status.primaryOscEnable       = primEnable_r;
  assign status.secondaryOscEnable     = secEnable_r;

  // software-owned bits passed through unchanged
  assign clockSourceSelectEcho = clockSourceSelect;
  assign idleOnSleepEcho       = idleOnSleepEnable;
  assign internalFreqOut       = internalFreqSelect;

  // pipeline
  logic [PC_W-1:0]   pc_r;
  logic [INSN_W-1:0] fetch_r;
  logic [INSN_W-1:0] ir_r;
  logic              irValid_r;
  logic              flush_r;

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pc_r <= '0;
    else if (phase_r == PH_ONE)
      pc_r <= pc_r + PC_STEP;
    else if (phase_r == PH_FOUR && branchTaken && irValid_r)
      pc_r <= branchTarget;
  end

  // fetched word latched in phase four
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      fetch_r <= INSN_NOP;
    else if (phase_r == PH_FOUR)
      fetch_r <= progMemData;
  end

  // flush discards the word fetched alongside a branch
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flush_r <= 1'b0;
    else if (phase_r == PH_FOUR)
      flush_r <= branchTaken && irValid_r;
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir_r      <= INSN_NOP;
      irValid_r <= 1'b0;
    end
    else if (phase_r == PH_ONE)
    begin
      ir_r      <= fetch_r;
      irValid_r <= !flush_r;
    end
  end

  assign progCounter = pc_r;
  assign instrReg    = ir_r;
  assign instrValid  = irValid_r;
  assign operandRead = irValid_r && (phase_r == PH_TWO);
  assign destWrite   = irValid_r && (phase_r == PH_FOUR);

  // checks on the switch, the phases and the pipeline
  AST_PHASE_ADVANCE: assert property (@(posedge clock) disable iff (!rst_n)
    phase_r == PH_FOUR |=> phase_r == PH_ONE ##1 phase_r == PH_TWO)
    else $error("phase sequence broken");
  AST_PC_STEP: assert property (@(posedge clock) disable iff (!rst_n)
    phase_r == PH_ONE |=> pc_r == $past(pc_r) + PC_STEP)
    else $error("pc not stepped in phase one");
  AST_SWITCH_BOUNDARY: assert property (@(posedge clock) disable iff (!rst_n)
    active_r != $past(active_r) |-> phase_r == PH_ONE)
    else $error("source changed mid cycle");
  AST_PRI_WAITS: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(active_r) && active_r == SRC_PRIMARY |-> $past(primReadySync2_r))
    else $error("primary used before ready");
  AST_PRI_ENABLED: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(active_r) && active_r == SRC_PRIMARY |-> $past(primEnable_r, 2) && $past(primEnable_r, 3))
    else $error("primary used straight after restart");
  AST_PRI_ON_REQ: assert property (@(posedge clock) disable iff (!rst_n)
    requested == SRC_PRIMARY |=> primEnable_r)
    else $error("primary not started on request");
  AST_SEC_FLAG: assert property (@(posedge clock) disable iff (!rst_n)
    active_r == SRC_PRIMARY && $past(active_r) == SRC_PRIMARY |=> !secActive_r)
    else $error("secondary flag stuck");
  AST_RETURN_FLAGS: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(active_r) && active_r == SRC_PRIMARY && $past(active_r) == SRC_SECONDARY
    |=> !secActive_r && timeout_r)
    else $error("flags wrong after return to primary");
  AST_INT_STOPS_PRI: assert property (@(posedge clock) disable iff (!rst_n)
    active_r == SRC_INTERNAL && requested == SRC_INTERNAL |=> !primEnable_r && !timeout_r)
    else $error("primary not stopped in internal run");
  AST_SEC_KEPT: assert property (@(posedge clock) disable iff (!rst_n)
    secEnable_r |=> secEnable_r)
    else $error("secondary oscillator stopped");
  AST_SEC_ON: assert property (@(posedge clock) disable iff (!rst_n)
    requested == SRC_SECONDARY |=> secEnable_r)
    else $error("secondary oscillator not started");
  AST_SWITCH_DELAY: assert property (@(posedge clock) disable iff (!rst_n)
    $changed(active_r) |-> $past(switchPending_r))
    else $error("switch without delay");
  AST_ECHO: assert property (@(posedge clock) disable iff (!rst_n)
    clockSourceSelectEcho == clockSourceSelect && idleOnSleepEcho == idleOnSleepEnable)
    else $error("software bits altered");
  AST_FREQ_NOW: assert property (@(posedge clock) disable iff (!rst_n)
    internalFreqOut == internalFreqSelect)
    else $error("frequency select not applied at once");
  AST_FETCH_P4: assert property (@(posedge clock) disable iff (!rst_n)
    phase_r == PH_FOUR |=> fetch_r == $past(progMemData))
    else $error("fetch not latched in phase four");
  AST_IR_LOAD: assert property (@(posedge clock) disable iff (!rst_n)
    phase_r == PH_ONE |=> ir_r == $past(fetch_r))
    else $error("instruction register not loaded");
  AST_IR_STABLE: assert property (@(posedge clock) disable iff (!rst_n)
    phase_r != PH_ONE |=> $stable(ir_r) && $stable(irValid_r))
    else $error("instruction changed during execute");
  AST_FLUSH: assert property (@(posedge clock) disable iff (!rst_n)
    phase_r == PH_FOUR && branchTaken && irValid_r |=> ##1 !irValid_r)
    else $error("branch did not flush");
  AST_BRANCH_PC: assert property (@(posedge clock) disable iff (!rst_n)
    phase_r == PH_FOUR && branchTaken && irValid_r |=> pc_r == $past(branchTarget))
    else $error("branch target not loaded");
  AST_WRITE_P4: assert property (@(posedge clock) disable iff (!rst_n)
    operandRead |-> ##2 destWrite)
    else $error("write not in phase four");

  // main switching and branch paths
  COV_TO_INTERNAL: cover property (@(posedge clock) disable iff (!rst_n)
    active_r == SRC_PRIMARY ##[1:40] active_r == SRC_INTERNAL);
  COV_SEC_TO_PRI: cover property (@(posedge clock) disable iff (!rst_n)
    active_r == SRC_SECONDARY ##[1:40] active_r == SRC_PRIMARY);
  COV_INT_TO_PRI: cover property (@(posedge clock) disable iff (!rst_n)
    active_r == SRC_INTERNAL ##[1:60] active_r == SRC_PRIMARY);
  COV_BRANCH: cover property (@(posedge clock) disable iff (!rst_n)
    phase_r == PH_FOUR && branchTaken && irValid_r);

endmodule

// ===== testbench/rmcs_primary_osc_model.sv
// primary oscillator model: start-up delay, then ready
`timescale 1ns/1ps
module rmcs_primary_osc_model #(
  parameter int START_CYC = 12
)(
  input  wire logic clock,
  input  wire logic enable,
  output logic      ready
);
  int cnt = 0;
  initial
  begin
    ready = 1'b0;
  end
  // ready only once enable has held for the start-up time; drops at shutdown
  always @(posedge clock)
  begin
    cnt   <= enable ? cnt + 1 : 0;
    ready <= enable && cnt >= START_CYC;
  end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the clock switch and pipeline
`timescale 1ns/1ps
module testbench;
  import rmcs_pkg::*;
  logic [SEL_W-1:0]   clockSourceSelect = SEL_PRIMARY;
  logic [FREQ_W-1:0]  internalFreqSelect = FREQ_RESET;
  logic [INSN_W-1:0]  progMemData = INSN_NOP;
  logic [PC_W-1:0]    branchTarget = '0;
  logic               clock = 1'b0, rst_n = 1'b0, idleOnSleepEnable = 1'b0, branchTaken = 1'b0;
  logic               primaryReadyPin, idleOnSleepEcho, instrValid, operandRead, destWrite, sawReady, havePc;
  rmcs_src_t          activeSource;
  rmcs_status_t       status;
  logic [SEL_W-1:0]   clockSourceSelectEcho;
  logic [FREQ_W-1:0]  internalFreqOut;
  logic [PHASE_W-1:0] phase;
  logic [PC_W-1:0]    progCounter, lastPc, branchDest;
  logic [INSN_W-1:0]  instrReg, fetched = INSN_NOP;
  logic [31:0]        rnd;
  int                 errors = 0, total_checks = 0, cyc = 0, seed = 32'h4035CEB7;

  rmcs_clock_switch i_rmcs_clock_switch (.clock, .rst_n, .clockSourceSelect, .idleOnSleepEnable,
    .internalFreqSelect, .primaryReadyPin, .progMemData, .branchTaken, .branchTarget, .activeSource,
    .status, .clockSourceSelectEcho, .idleOnSleepEcho, .internalFreqOut, .phase, .progCounter,
    .instrReg, .instrValid, .operandRead, .destWrite);
  rmcs_primary_osc_model #(.START_CYC(12)) i_rmcs_primary_osc_model (.clock,
    .enable(status.primaryOscEnable), .ready(primaryReadyPin));

  always #4 clock = ~clock;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // wait for a source change, bounded
  task automatic waitSrc(input rmcs_src_t s);
    int n;
    n = 0;
    sawReady = 1'b0;
    while (activeSource !== s && n < 300)
    begin
      @(negedge clock);
      sawReady = sawReady | primaryReadyPin;
      n++;
    end
    chk("source", s, activeSource);
    chk("switch delay", 1, n > 1);
    chk("boundary phase", PH_ONE, phase);
  endtask

  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  end

  always @(posedge clock)
  begin
    rnd = $random(seed);
    internalFreqSelect <= rnd[2:0];
    idleOnSleepEnable  <= rnd[3];
    progMemData        <= rnd[31:16];
    branchTarget       <= {5'h00, rnd[15:0]};
  end

  // continuous port monitor
  always @(negedge clock)
    if (rst_n)
    begin
      chk("freq echo", internalFreqSelect, internalFreqOut);
      chk("sel echo", clockSourceSelect, clockSourceSelectEcho);
      chk("idle echo", idleOnSleepEnable, idleOnSleepEcho);
      chk("read strobe", instrValid && phase == PH_TWO, operandRead);
      chk("write strobe", instrValid && phase == PH_FOUR, destWrite);
      if (phase == PH_FOUR)
        fetched = progMemData;
      if (phase == PH_TWO && instrValid)
        chk("instr reg", fetched, instrReg);
      if (phase == PH_THREE)
      begin
        if (havePc)
          chk("pc step", lastPc + PC_STEP, progCounter);
        lastPc = progCounter;
        havePc = 1'b1;
      end
    end

  initial
  begin
    havePc = 1'b0;
    repeat (6) @(posedge clock);
    chk("reset source", SRC_PRIMARY, activeSource);
    chk("reset status", 4'h2, status);
    rst_n <= 1'b1;
    repeat (60) @(posedge clock);
    $display("test pipeline done");
    @(negedge clock iff (phase == PH_THREE && instrValid));
    @(posedge clock);
    branchTaken <= 1'b1;
    @(negedge clock);
    branchDest = branchTarget;
    @(posedge clock);
    branchTaken <= 1'b0;
    havePc = 1'b0;
    @(negedge clock iff (phase == PH_TWO));
    chk("flushed", 0, instrValid);
    chk("branch pc", branchDest + PC_STEP, progCounter);
    @(negedge clock iff (phase == PH_TWO));
    chk("refilled", 1, instrValid);
    $display("test branch done");
    for (int lo = 0; lo < 2; lo++)
    begin
      @(posedge clock);
      clockSourceSelect <= {1'b1, lo[0]};
      waitSrc(SRC_INTERNAL);
      @(negedge clock);
      chk("primary off", 0, status.primaryOscEnable);
      chk("timeout flag", 0, status.oscStartTimeoutFlag);
      @(posedge clock);
      clockSourceSelect <= SEL_PRIMARY;
      waitSrc(SRC_PRIMARY);
      chk("ready before", 1, sawReady);
      $display("test internal %0d done", lo);
    end
    @(posedge clock);
    clockSourceSelect <= {1'b1, 1'b0};
    waitSrc(SRC_INTERNAL);
    @(posedge clock);
    clockSourceSelect <= SEL_SECONDARY;
    waitSrc(SRC_SECONDARY);
    @(negedge clock);
    chk("sec active", 1, status.secondaryOscActiveFlag);
    @(posedge clock);
    clockSourceSelect <= SEL_PRIMARY;
    waitSrc(SRC_PRIMARY);
    chk("ready before", 1, sawReady);
    repeat (2) @(negedge clock);
    chk("sec flag", 0, status.secondaryOscActiveFlag);
    chk("timeout flag", 1, status.oscStartTimeoutFlag);
    chk("sec running", 1, status.secondaryOscEnable);
    $display("test secondary done");
    tally_and_finish();
  end
endmodule
